// ===== dv/scsc_partner.sv
// Far side of the start control block: timer overflow pulses, external
// start pin and the free-running low-power oscillator.
// Assumes requests arrive from the bench just after a rising edge of i_clk.
`timescale 1ns/10ps
`default_nettype none

module scsc_partner (
	input wire logic i_clk,
	input wire logic i_fire,
	input wire logic [2:0] i_line,
	output logic [4:0] o_ovf,
	output logic o_ext_start,
	output logic o_lposc
);
	int ext_left;

	// ****************************************
	// Oscillator, 60 ns period, edges kept off the system clock edges
	// ****************************************
	initial
	begin
		o_lposc = 1'b0;
		#3;
		forever
		begin
			#30 o_lposc = ~o_lposc;
		end
	end

	// ****************************************
	// Overflow pulses last one cycle; the pin stays high 8 cycles
	// ****************************************
	initial
	begin
		o_ovf = '0;
		o_ext_start = 1'b0;
		ext_left = 0;
	end

	always @(posedge i_clk)
	begin
		o_ovf <= '0;
		if (i_fire && i_line < 3'h5)
			o_ovf[i_line] <= 1'b1;
		ext_left <= (i_fire && i_line == 3'h5) ? 8 : (ext_left > 0 ? ext_left - 1 : 0);
		// The pin is driven by nothing else, as if the crossbar skips it
		o_ext_start <= (i_fire && i_line == 3'h5) || ext_left > 1;
	end
endmodule

`default_nettype wire

// ===== dv/scsc_top_bench.sv
// Self-checking bench for the converter start control block.
// Assumes the partner model for timers, start pin and oscillator.
`timescale 1ns/10ps
`default_nettype none

module scsc_top_bench;
	import scsc_pkg::*;
	logic clk, rst_n, psel, pen, pwr, pready, pslverr, fire, split, ext, lposc;
	logic tick, trk, conv, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r, v, seed;
	logic [4:0] ovf;
	logic [2:0] line;
	logic [9:0] res;
	logic [31:0] exp_q[$];
	int fails, checks_done, cyc, trk_cnt, last_tick, spacing, tk, base;
	bit in_conv;

	scsc_top #(.CONV_CLKS(4), .BURST_LEN(3)) u_dut (.I_CLK(clk), .I_RESET_N(rst_n),
		.I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_TMR0_OVF(ovf[0]),
		.I_TMR2_LOW_OVF(ovf[1]), .I_TMR2_HIGH_OVF(ovf[2]), .I_TMR2_SPLIT(split),
		.I_TMR3_LOW_OVF(ovf[3]), .I_TMR3_HIGH_OVF(ovf[4]), .I_TMR3_SPLIT(split),
		.I_EXT_START(ext), .I_LPOSC(lposc), .I_SAR_RESULT(res), .O_SAR_TICK(tick),
		.O_SAR_TRACK(trk), .O_SAR_CONVERT(conv), .O_IRQ(irq));
	scsc_partner u_partner (.i_clk(clk), .i_fire(fire), .i_line(line), .o_ovf(ovf),
		.o_ext_start(ext), .o_lposc(lposc));

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string what);
		checks_done++;
		if (seen !== want)
		begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic pulse(input logic [2:0] l);
		fire <= 1'b1;
		line <= l;
		@(posedge clk);
		fire <= 1'b0;
	endtask

	task automatic arm();
		logic [31:0] a;
		a = xs();
		res <= a[9:0];
		exp_q.push_back(a & 32'h3ff);
	endtask

	task automatic finish_conv();
		logic [31:0] q, e;
		int n;
		n = 0;
		e = exp_q.pop_front();
		while (irq !== 1'b1 && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		chk(irq, 1, "irq");
		rd(ADDR_CONTROL, q);
		chk(q[5:4], 2'h2, "done and busy");
		rd(ADDR_RES_LOW, q);
		chk(q, e & 32'hff, "result low");
		rd(ADDR_RES_HIGH, q);
		chk(q, e >> 8, "result high");
		wr(ADDR_INT_STATUS, 32'h1);
		chk(irq, 0, "irq cleared");
	endtask

	// ****************************************
	// Clock, tick and track monitor, timeout
	// ****************************************
	initial
	begin
		clk = 1'b0;
		forever
		begin
			#5 clk = ~clk;
		end
	end

	always @(posedge clk)
	begin
		cyc++;
		if (trk === 1'b1)
			trk_cnt++;
		if (tick === 1'b1)
		begin
			if (conv === 1'b1 && in_conv)
				spacing = cyc - last_tick;
			last_tick = cyc;
			in_conv = (conv === 1'b1);
		end
		if (cyc > 40000)
		begin
			fails++;
			give_verdict();
		end
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial
	begin
		{rst_n, psel, pen, pwr, fire, split} = '0;
		{paddr, pwdata, line, res} = '0;
		seed = 32'd89457;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		exp_q.delete();
		rd(ADDR_TRACK, r);
		chk(r, 32'h1e, "track reset");
		rd(ADDR_CONFIG, r);
		chk(r, 32'h0, "config reset");
		rd(ADDR_CONTROL, r);
		chk(r, 32'h0, "control reset");
		apb(1'b0, 8'h20, 32'h0, r, split);
		chk(split, 1, "unmapped error");
		split <= 1'b0;
		wr(ADDR_TRACK, 32'h7f);
		rd(ADDR_TRACK, r);
		chk(r, 32'h3f, "track upper bits");
		wr(ADDR_INT_MASK, 32'h1);
		for (int c = 0; c < 6; c++)
		begin
			v = xs();
			split <= v[0];
			wr(ADDR_CONTROL, c);
			if (c < 5)
				arm();
			pulse(c == 0 ? 3'h0 : c == 1 ? 3'h1 : c == 2 ? (v[0] ? 3'h2 : 3'h1) :
				c == 3 ? (v[0] ? 3'h4 : 3'h3) : c == 4 ? 3'h0 : 3'h5);
			repeat (20) @(posedge clk);
			rd(ADDR_INT_STATUS, r);
			chk(r, 32'h0, "wrong source ignored");
			if (c == 0)
				wr(ADDR_CONTROL, 32'h10);
			else if (c < 5)
				pulse(c == 1 ? 3'h0 : c == 2 ? (v[0] ? 3'h1 : 3'h2) :
					c == 3 ? (v[0] ? 3'h3 : 3'h4) : 3'h5);
			if (c < 5)
				finish_conv();
		end
		wr(ADDR_CONTROL, 32'h0);
		wr(ADDR_CONFIG, 32'h1f);
		arm();
		wr(ADDR_CONTROL, 32'h10);
		repeat (10) @(posedge clk);
		wr(ADDR_CONTROL, 32'h10);
		finish_conv();
		chk(spacing, 32, "tick spacing divided");
		repeat (150) @(posedge clk);
		rd(ADDR_INT_STATUS, r);
		chk(r, 32'h0, "no restart while busy");
		wr(ADDR_INT_MASK, 32'h0);
		wr(ADDR_CONFIG, 32'h1);
		arm();
		wr(ADDR_CONTROL, 32'h10);
		repeat (20) @(posedge clk);
		chk(irq, 0, "masked irq");
		rd(ADDR_INT_STATUS, r);
		chk(r, 32'h1, "done while masked");
		wr(ADDR_INT_MASK, 32'h1);
		finish_conv();
		chk(spacing, 2, "tick spacing by two");
		for (int tm = 0; tm < 2; tm++)
		begin
			tk = 40 + xs() % 24;
			wr(ADDR_TRACK, tk);
			wr(ADDR_CONFIG, 32'h41 | (tm << 5));
			arm();
			trk_cnt = 0;
			wr(ADDR_CONTROL, 32'h10);
			finish_conv();
			base = 2 * (64 - tk) * 5;
			if (tm == 0)
				chk(trk_cnt, base, "burst track cycles");
			else
				chk(trk_cnt >= base + 48, 1, "extra track cycles");
			chk(spacing, 12, "oscillator tick spacing");
		end
		give_verdict();
	end
endmodule

`default_nettype wire

// ===== shared/scsc_pkg.sv
// Constants for the converter start control block: register map, fields,
// reset values, trigger codes, sequencer states and timing.
// Assumes a 100 MHz system clock and a 32-bit APB register bus.
package scsc_pkg;

	// ****************************************
	// Register byte addresses
	// ****************************************
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_CONTROL = 8'h04;
	localparam logic [7:0] ADDR_RES_LOW = 8'h08;
	localparam logic [7:0] ADDR_RES_HIGH = 8'h0c;
	localparam logic [7:0] ADDR_INT_STATUS = 8'h10;
	localparam logic [7:0] ADDR_INT_MASK = 8'h14;
	localparam logic [7:0] ADDR_TRACK = 8'hbc;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CFG_DIV_LSB = 0;
	localparam int CFG_TRACK_MODE_BIT = 5;
	localparam int CFG_BURST_BIT = 6;
	localparam int CTL_SEL_LSB = 0;
	localparam int CTL_BUSY_BIT = 4;
	localparam int CTL_DONE_BIT = 5;
	localparam int INT_DONE_BIT = 0;
	localparam int TRACK_FIELD_W = 6;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [5:0] TRACK_RESET = 6'h1e;
	localparam logic [4:0] DIV_RESET = 5'h00;
	localparam logic [2:0] SEL_RESET = 3'h0;

	// ****************************************
	// Start-select codes; 5 to 7 start nothing
	// ****************************************
	localparam logic [2:0] SEL_SOFTWARE = 3'h0;
	localparam logic [2:0] SEL_TMR0 = 3'h1;
	localparam logic [2:0] SEL_TMR2 = 3'h2;
	localparam logic [2:0] SEL_TMR3 = 3'h3;
	localparam logic [2:0] SEL_EXTERNAL = 3'h4;

	typedef enum logic [1:0] {ST_IDLE, ST_GAP, ST_EXTRA, ST_CONV} scsc_state_e;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_FREQ_MHZ = 100;
	localparam int CLK_PERIOD_NS = 1000 / CLK_FREQ_MHZ;
	localparam int TRACK_STEP_NS = 50;
	localparam logic [2:0] TRACK_STEP_CYCLES =
		3'((TRACK_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [6:0] TRACK_SLOTS = 7'h40;
	localparam int EXTRA_TRACK_CLKS = 3;

endpackage

// ===== verilog/scsc_top.sv
// Start control for a successive-approximation converter: clock source and
// divider, trigger selection, busy and done status, burst tracking delays.
// Assumes an APB master on I_CLK, timer overflow pulses from logic on I_CLK,
// and an analog core that presents its result on I_SAR_RESULT at the end.
//
// How it works
// - Converter clock source is system clock, or low-power oscillator in burst mode.
// - Source clock is divided by the divider field of the config register plus one.
// - One of five trigger sources is chosen by the three-bit start select.
// - With software select, writing one to the busy bit starts a conversion.
// - Timer 0, 2 or 3 overflow starts a conversion when selected.
// - A rising edge on the external start input starts a conversion when selected.
// - Busy bit reads one throughout a conversion and zero once it finishes.
// - Busy falling sets the done flag; interrupt raised when enabled.
// - Result bytes hold a valid result while the done flag is one.
// - Timers 2 and 3 use low-byte overflow in 8-bit, high-byte in 16-bit.
// - Burst conversions after the first wait (64 minus track time) times 50 ns.
// - Track mode bit adds three converter clocks of tracking before conversion.
// - The first conversion of a burst gets no tracking delay.
// - Track register bits 7 and 6 read zero; writes there are dropped.
// - Track-time field sits in bits 5 to 0 at address 0xbc.
// - Conversion timing supports 300 ksps at 10-bit resolution.
`timescale 1ns/10ps
`default_nettype none

module scsc_top #(
	parameter int DIV_W = 5,
	parameter int RES_W = 10,
	parameter int CONV_CLKS = 12,
	parameter int BURST_LEN = 4
) (
	input wire logic I_CLK,
	input wire logic I_RESET_N,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic I_TMR0_OVF,
	input wire logic I_TMR2_LOW_OVF,
	input wire logic I_TMR2_HIGH_OVF,
	input wire logic I_TMR2_SPLIT,
	input wire logic I_TMR3_LOW_OVF,
	input wire logic I_TMR3_HIGH_OVF,
	input wire logic I_TMR3_SPLIT,
	input wire logic I_EXT_START,
	input wire logic I_LPOSC,
	input wire logic [RES_W-1:0] I_SAR_RESULT,
	output logic O_SAR_TICK,
	output logic O_SAR_TRACK,
	output logic O_SAR_CONVERT,
	output logic O_IRQ
);
	import scsc_pkg::*;

	localparam int CNT_W = 10;

	if (DIV_W < 1 || DIV_W > 5 || RES_W < 9 || RES_W > 16)
	begin : g_bad_width
		$error("scsc_top: DIV_W must be 1..5 and RES_W 9..16");
	end
	if (CONV_CLKS < 1 || CONV_CLKS > 1023 || BURST_LEN < 1 || BURST_LEN > 64)
	begin : g_bad_count
		$error("scsc_top: CONV_CLKS must be 1..1023 and BURST_LEN 1..64");
	end

	typedef struct packed {
		scsc_state_e st;
		logic [DIV_W-1:0] cfg_div;
		logic cfg_tm;
		logic cfg_burst;
		logic [2:0] sel;
		logic [5:0] track;
		logic done;
		logic mask;
		logic [RES_W-1:0] result;
		logic ext_s1;
		logic ext_s2;
		logic ext_s3;
		logic osc_s1;
		logic osc_s2;
		logic osc_s3;
		logic [DIV_W-1:0] div_cnt;
		logic tick;
		logic [CNT_W-1:0] cnt;
		logic [6:0] burst_left;
		logic [31:0] prdata;
		logic pslverr;
	} scsc_regs_s;

	localparam scsc_regs_s S_RESET = '{
		st: ST_IDLE,
		cfg_div: DIV_W'(DIV_RESET),
		sel: SEL_RESET,
		track: TRACK_RESET,
		default: '0
	};

	scsc_regs_s s_q;
	scsc_regs_s s_d;

	// ****************************************
	// Trigger selection
	// ****************************************
	// Timers 2 and 3 pick the byte whose overflow matches their counting mode
	function automatic logic sel_trigger(input logic [2:0] sel, input logic sw,
		input logic t0, input logic t2, input logic t3, input logic ext);
		logic hit;
		hit = 1'b0;
		unique case (sel)
			SEL_SOFTWARE: hit = sw;
			SEL_TMR0: hit = t0;
			SEL_TMR2: hit = t2;
			SEL_TMR3: hit = t3;
			SEL_EXTERNAL: hit = ext;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	logic apb_wr;
	logic apb_setup;
	logic ext_rise;
	logic osc_rise;
	logic src_tick;
	logic sw_start;
	logic tmr2_ovf;
	logic tmr3_ovf;
	logic trig;
	logic busy;
	logic done_clr;
	logic [6:0] slots_left;
	logic [CNT_W-1:0] gap_len;
	logic [15:0] res16;

	assign apb_wr = I_PSEL & I_PENABLE & I_PWRITE;
	assign apb_setup = I_PSEL & ~I_PENABLE;
	assign ext_rise = s_q.ext_s2 & ~s_q.ext_s3;
	assign osc_rise = s_q.osc_s2 & ~s_q.osc_s3;
	assign src_tick = s_q.cfg_burst ? osc_rise : 1'b1;
	assign tmr2_ovf = I_TMR2_SPLIT ? I_TMR2_LOW_OVF : I_TMR2_HIGH_OVF;
	assign tmr3_ovf = I_TMR3_SPLIT ? I_TMR3_LOW_OVF : I_TMR3_HIGH_OVF;
	assign sw_start = apb_wr & (I_PADDR == ADDR_CONTROL) & I_PWDATA[CTL_BUSY_BIT];
	assign trig = sel_trigger(s_q.sel, sw_start, I_TMR0_OVF, tmr2_ovf, tmr3_ovf,
		ext_rise);
	assign busy = (s_q.st != ST_IDLE);
	assign done_clr = apb_wr & (I_PADDR == ADDR_INT_STATUS) & I_PWDATA[INT_DONE_BIT];
	assign slots_left = TRACK_SLOTS - {1'b0, s_q.track};
	assign gap_len = {3'h0, slots_left} * {7'h0, TRACK_STEP_CYCLES};
	assign res16 = 16'(s_q.result);

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb
	begin
		s_d = s_q;
		s_d.tick = 1'b0;
		s_d.ext_s1 = I_EXT_START;
		s_d.ext_s2 = s_q.ext_s1;
		s_d.ext_s3 = s_q.ext_s2;
		s_d.osc_s1 = I_LPOSC;
		s_d.osc_s2 = s_q.osc_s1;
		s_d.osc_s3 = s_q.osc_s2;

		// Divider runs freely so the converter clock phase never depends on software
		// Lowering the divisor must not strand the counter above it for a full wrap
		if (src_tick)
		begin
			if (s_q.div_cnt >= s_q.cfg_div)
			begin
				s_d.div_cnt = '0;
				s_d.tick = 1'b1;
			end
			else
			begin
				s_d.div_cnt = s_q.div_cnt + 1'b1;
			end
		end

		if (apb_wr)
		begin
			unique case (I_PADDR)
				ADDR_CONFIG:
				begin
					s_d.cfg_div = I_PWDATA[CFG_DIV_LSB +: DIV_W];
					s_d.cfg_tm = I_PWDATA[CFG_TRACK_MODE_BIT];
					s_d.cfg_burst = I_PWDATA[CFG_BURST_BIT];
				end
				ADDR_CONTROL: s_d.sel = I_PWDATA[CTL_SEL_LSB +: 3];
				ADDR_INT_MASK: s_d.mask = I_PWDATA[INT_DONE_BIT];
				ADDR_TRACK: s_d.track = I_PWDATA[TRACK_FIELD_W-1:0];
				default: s_d.sel = s_q.sel;
			endcase
		end

		// A clear that meets a new completion loses to it
		s_d.done = s_q.done & ~done_clr;

		unique case (s_q.st)
			ST_IDLE:
			begin
				// Only an idle sequencer listens to triggers
				if (trig)
				begin
					s_d.burst_left = s_q.cfg_burst ? 7'(BURST_LEN - 1) : 7'h00;
					s_d.cnt = '0;
					s_d.st = s_q.cfg_tm ? ST_EXTRA : ST_CONV;
				end
			end
			ST_GAP:
			begin
				if (s_q.cnt == gap_len - 1'b1)
				begin
					s_d.cnt = '0;
					s_d.st = s_q.cfg_tm ? ST_EXTRA : ST_CONV;
				end
				else
				begin
					s_d.cnt = s_q.cnt + 1'b1;
				end
			end
			ST_EXTRA:
			begin
				if (s_q.tick)
				begin
					if (s_q.cnt == CNT_W'(EXTRA_TRACK_CLKS - 1))
					begin
						s_d.cnt = '0;
						s_d.st = ST_CONV;
					end
					else
					begin
						s_d.cnt = s_q.cnt + 1'b1;
					end
				end
			end
			ST_CONV:
			begin
				// CONV_CLKS sets the throughput; 12 clocks at 4 MHz give 333 ksps
				if (s_q.tick)
				begin
					if (s_q.cnt == CNT_W'(CONV_CLKS - 1))
					begin
						s_d.cnt = '0;
						s_d.result = I_SAR_RESULT;
						if (s_q.burst_left != 7'h00)
						begin
							s_d.burst_left = s_q.burst_left - 1'b1;
							s_d.st = ST_GAP;
						end
						else
						begin
							s_d.st = ST_IDLE;
							s_d.done = 1'b1;
						end
					end
					else
					begin
						s_d.cnt = s_q.cnt + 1'b1;
					end
				end
			end
		endcase

		// ****************************************
		// APB read data, latched in the setup cycle
		// ****************************************
		if (apb_setup)
		begin
			s_d.prdata = 32'h0;
			s_d.pslverr = 1'b0;
			unique case (I_PADDR)
				ADDR_CONFIG:
				begin
					s_d.prdata[CFG_DIV_LSB +: DIV_W] = s_q.cfg_div;
					s_d.prdata[CFG_TRACK_MODE_BIT] = s_q.cfg_tm;
					s_d.prdata[CFG_BURST_BIT] = s_q.cfg_burst;
				end
				ADDR_CONTROL:
				begin
					s_d.prdata[CTL_SEL_LSB +: 3] = s_q.sel;
					s_d.prdata[CTL_BUSY_BIT] = busy;
					s_d.prdata[CTL_DONE_BIT] = s_q.done;
				end
				ADDR_RES_LOW: s_d.prdata[7:0] = res16[7:0];
				ADDR_RES_HIGH: s_d.prdata[7:0] = res16[15:8];
				ADDR_INT_STATUS: s_d.prdata[INT_DONE_BIT] = s_q.done;
				ADDR_INT_MASK: s_d.prdata[INT_DONE_BIT] = s_q.mask;
				ADDR_TRACK: s_d.prdata[TRACK_FIELD_W-1:0] = s_q.track;
				default: s_d.pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge I_CLK)
	begin
		if (!I_RESET_N)
			s_q <= S_RESET;
		else
			s_q <= s_d;
	end

	assign O_PRDATA = s_q.prdata;
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = s_q.pslverr;
	assign O_SAR_TICK = s_q.tick;
	assign O_SAR_TRACK = (s_q.st == ST_GAP) | (s_q.st == ST_EXTRA);
	assign O_SAR_CONVERT = (s_q.st == ST_CONV);
	assign O_IRQ = s_q.done & s_q.mask;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RESET_N);

	a_source_sys_clock: assert property (
		I_RESET_N && !s_q.cfg_burst && s_q.cfg_div == '0 && !apb_wr |=> s_q.tick)
		else $error("converter clock missing on system clock source");
	a_source_lp_osc: assert property (
		s_q.cfg_burst && !osc_rise |=> !s_q.tick)
		else $error("converter clock ticked without oscillator edge");
	a_divider_period: assert property (
		s_q.tick && !s_q.cfg_burst && s_q.cfg_div == DIV_W'(1) && !apb_wr
		|=> !s_q.tick ##1 s_q.tick)
		else $error("divide by two not honoured");
	a_sw_start: assert property (
		!busy && s_q.sel == SEL_SOFTWARE && sw_start |=> busy)
		else $error("software start ignored");
	a_tmr0_start: assert property (
		!busy && s_q.sel == SEL_TMR0 && I_TMR0_OVF |=> busy)
		else $error("timer 0 overflow did not start");
	a_ext_start: assert property (
		!busy && s_q.sel == SEL_EXTERNAL && ext_rise |=> busy)
		else $error("external rising edge did not start");
	a_tmr2_byte: assert property (
		!busy && s_q.sel == SEL_TMR2 && I_TMR2_SPLIT && I_TMR2_HIGH_OVF
		&& !I_TMR2_LOW_OVF |=> !busy)
		else $error("timer 2 used wrong byte overflow");
	a_done_on_fall: assert property (
		$fell(busy) |-> s_q.done && (O_IRQ == s_q.mask))
		else $error("done flag not set at end of conversion");
	a_busy_read: assert property (
		apb_setup && I_PADDR == ADDR_CONTROL |=> O_PRDATA[CTL_BUSY_BIT] == $past(busy))
		else $error("busy bit reads wrong");
	a_result_hold: assert property (
		s_q.done && !busy && !$past(busy) |-> $stable(s_q.result))
		else $error("result changed while done and idle");
	a_gap_length: assert property (
		s_q.st == ST_GAP && s_q.cnt == gap_len - 1'b1 |=> s_q.st != ST_GAP)
		else $error("burst tracking delay has wrong length");
	a_extra_track: assert property (
		$rose(s_q.st == ST_CONV) && s_q.cfg_tm |-> $past(s_q.st) == ST_EXTRA)
		else $error("extra tracking clocks skipped");
	a_first_no_gap: assert property (
		!busy && trig |=> s_q.st != ST_GAP)
		else $error("first conversion got a tracking delay");
	a_track_upper: assert property (
		apb_setup && I_PADDR == ADDR_TRACK |=> O_PRDATA[7:6] == 2'b00)
		else $error("track register upper bits not zero");
	a_no_restart: assert property (
		s_q.st == ST_CONV && !s_q.tick && trig |=> s_q.cnt == $past(s_q.cnt))
		else $error("trigger disturbed running conversion");

endmodule

`default_nettype wire
